/* logic/imust_regs.sv */
// self-check, boot interface, trim and step tally register bank
// assumes an 8-bit internal register port from the serial front end,
// a boot loader that streams non-volatile bytes, and sensor samples
//
// Notes on behaviour
// - gyro check bit starts gyro self-test, status reported
// - amplitude bit: one high, zero low, resets low
// - sign bit: one positive, zero negative excitation
// - accel check field: 00 off, 01 running
// - accel self-test drives all three axes together
// - interface config loaded from storage at boot
// - bus watchdog on data pin when enabled
// - watchdog period: zero 1 ms, one 50 ms
// - serial-only bit disables two-wire in autoconfig
// - offsets added only while trim enable set
// - trim bytes restored from storage, may be saved
// - host writes or calibration result updates offsets
// - accel offset eight bit signed, 3.9 mg
// - gyro offset ten bit signed, 0.061 dps
// - bytes 0-2 accel, 3-5 gyro, 6 upper
// - read-only 16-bit step tally, low first
// - command 0xb2 clears step tally
// - command 0x03 runs calibration, stores offsets
`timescale 1ns/1ns
`include "imust_cfg.svh"
module imust_regs #(
  parameter int WDT_SHORT_CYC = `IMUST_WDT_SHORT_CYC,
  parameter int WDT_LONG_CYC = `IMUST_WDT_LONG_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port from the serial front end
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire imust_pkg::imust_byte_t reg_wdata,
  output imust_pkg::imust_byte_t reg_rdata,
  // non-volatile boot stream
  input wire logic nv_load,
  input wire logic [7:0] nv_addr,
  input wire imust_pkg::imust_byte_t nv_data,
  // calibration result stream
  input wire logic foc_done,
  input wire logic [2:0] foc_idx,
  input wire imust_pkg::imust_byte_t foc_data,
  // self-test hooks
  input wire logic gyr_check_ok,
  input wire logic acc_check_ok,
  output logic gyr_check_run,
  output logic [2:0] acc_check_axes,
  output logic acc_check_high,
  output logic acc_check_pos,
  output logic gyr_check_ok_flag,
  output logic acc_check_ok_flag,
  // primary interface steering
  input wire imust_pkg::imust_ifmode_e if_mode,
  input wire logic sda_pin,
  output logic two_wire_off,
  output logic bus_wdt_expired,
  // step detector and commands
  input wire logic step_pulse,
  output logic foc_start,
  // sensor datapath
  input wire logic samp_valid,
  input wire imust_pkg::imust_word_t acc_x,
  input wire imust_pkg::imust_word_t acc_y,
  input wire imust_pkg::imust_word_t acc_z,
  input wire imust_pkg::imust_word_t gyr_x,
  input wire imust_pkg::imust_word_t gyr_y,
  input wire imust_pkg::imust_word_t gyr_z,
  output imust_pkg::imust_word_t acc_x_o,
  output imust_pkg::imust_word_t acc_y_o,
  output imust_pkg::imust_word_t acc_z_o,
  output imust_pkg::imust_word_t gyr_x_o,
  output imust_pkg::imust_word_t gyr_y_o,
  output imust_pkg::imust_word_t gyr_z_o
);
  import imust_pkg::*;

  logic [7:0] check_q; // self-check control byte
  logic [7:0] boot_q; // boot interface config byte
  logic [15:0] tally_q; // step total
  logic [55:0] trim_img; // trim bytes as one word
  logic [7:0] trim_rd; // registered trim read data
  logic trim_wr; // any writer to trim storage
  logic [2:0] trim_idx; // byte being written
  logic [7:0] trim_wdata; // byte value written
  logic [7:0] rd_addr_q; // address of the read in flight
  logic [2:0] sda_sync_q; // data pin synchroniser
  logic sda_stable_q; // filtered data pin level
  logic [19:0] wdt_cnt_q; // watchdog low-time count
  logic tally_clr; // clear command seen
  logic [15:0] off_vec [6]; // sign-extended offsets
  logic [15:0] raw_vec [6]; // incoming samples
  logic acc_trim_on; // accel offsets applied
  logic gyr_trim_on; // gyro offsets applied
  logic [5:0] trim_on; // per-channel offset enable

  // bus, boot loader and calibration share one trim write port;
  // calibration wins since it reports a finished measurement
  // a bus write that collides with either stream is dropped, so the
  // host should leave the offsets alone while a calibration runs
  always_comb begin
    trim_wr = 1'b0;
    trim_idx = 3'h0;
    trim_wdata = 8'h00;
    if (foc_done) begin
      trim_wr = 1'b1;
      trim_idx = foc_idx;
      trim_wdata = foc_data;
    end else if (nv_load && nv_addr >= `IMUST_ADDR_TRIM0 &&
                 nv_addr <= `IMUST_ADDR_TRIM6) begin
      trim_wr = 1'b1;
      trim_idx = 3'(nv_addr - `IMUST_ADDR_TRIM0);
      trim_wdata = nv_data;
    end else if (reg_wr && reg_addr >= `IMUST_ADDR_TRIM0 &&
                 reg_addr <= `IMUST_ADDR_TRIM6) begin
      trim_wr = 1'b1;
      trim_idx = 3'(reg_addr - `IMUST_ADDR_TRIM0);
      trim_wdata = reg_wdata;
    end
  end

  // trim storage; byte order fixed by index
  // reads index storage straight off the bus address; the read mux
  // throws the byte away when the address is outside the trim range
  imust_trim_mem #(.DEPTH(7), .AW(3)) u_trim (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr_en(trim_wr),
    .wr_idx(trim_idx),
    .wr_data(trim_wdata),
    .rd_idx(3'(reg_addr - `IMUST_ADDR_TRIM0)),
    .rd_data(trim_rd),
    .image(trim_img)
  );

  // self-check control byte, reserved bits masked off
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      check_q <= `IMUST_CHECK_RST;
    end else if (reg_wr && reg_addr == `IMUST_ADDR_CHECK) begin
      check_q <= reg_wdata & `IMUST_CHECK_MASK;
    end
  end

  // drives are registered off the control byte, so they follow a
  // write by two edges; the sensor side never sees a half-written byte
  // self-test drive lines
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gyr_check_run <= 1'b0;
      acc_check_axes <= 3'h0;
      acc_check_high <= 1'b0;
      acc_check_pos <= 1'b0;
    end else begin
      gyr_check_run <= check_q[`IMUST_BIT_GYR_CHK];
      // only code 01 runs; other codes leave the test off
      acc_check_axes <= {3{check_q[1:0] == `IMUST_ACC_RUN}};
      acc_check_high <= check_q[`IMUST_BIT_AMP];
      acc_check_pos <= check_q[`IMUST_BIT_SIGN];
    end
  end

  // self-test outcome flags for the status register
  // qualified by the enable so a stale pass from an earlier run
  // never shows once the test is switched off
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gyr_check_ok_flag <= 1'b0;
      acc_check_ok_flag <= 1'b0;
    end else begin
      gyr_check_ok_flag <= check_q[`IMUST_BIT_GYR_CHK] & gyr_check_ok;
      acc_check_ok_flag <= (check_q[1:0] == `IMUST_ACC_RUN) & acc_check_ok;
    end
  end

  // boot interface byte: reset to zero, then boot stream, then bus
  // a bus write in the same cycle as a boot byte loses, so the
  // stored contents are what the interface comes up with
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      boot_q <= 8'h00;
    end else if (nv_load && nv_addr == `IMUST_ADDR_BOOT) begin
      boot_q <= nv_data & `IMUST_BOOT_MASK;
    end else if (reg_wr && reg_addr == `IMUST_ADDR_BOOT) begin
      boot_q <= reg_wdata & `IMUST_BOOT_MASK;
    end
  end

  // serial-only steering, meaningful only in autoconfig modes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      two_wire_off <= 1'b0;
    end else begin
      two_wire_off <= boot_q[`IMUST_BIT_SER_ONLY] &&
        (if_mode == IMUST_IF_AUTO || if_mode == IMUST_IF_AUTO_MAG);
    end
  end

  // data pin comes from outside: three flops, last two must agree
  // reset to the idle high level so release gives no false low
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sda_sync_q <= 3'h7;
      sda_stable_q <= 1'b1;
    end else begin
      sda_sync_q <= {sda_sync_q[1:0], sda_pin};
      if (sda_sync_q[2] == sda_sync_q[1]) begin
        sda_stable_q <= sda_sync_q[2];
      end
    end
  end

  // watchdog: a data line held low too long releases the bus;
  // it only runs in two-wire mode so serial traffic cannot trip it
  // the count parks at the period so the flag holds until the line
  // rises; one shared counter serves both periods to save flops
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wdt_cnt_q <= 20'h00000;
      bus_wdt_expired <= 1'b0;
    end else if (!boot_q[`IMUST_BIT_WDT_EN] || two_wire_off ||
                 if_mode == IMUST_IF_RSVD || sda_stable_q) begin
      wdt_cnt_q <= 20'h00000;
      bus_wdt_expired <= 1'b0;
    end else if (wdt_cnt_q == (boot_q[`IMUST_BIT_WDT_SEL] ?
                 20'(WDT_LONG_CYC - 1) : 20'(WDT_SHORT_CYC - 1))) begin
      bus_wdt_expired <= 1'b1;
    end else begin
      wdt_cnt_q <= wdt_cnt_q + 20'h00001;
    end
  end

  // command decode for this bank's commands
  // other codes belong to the command block and are ignored here;
  // the calibration start is a one-cycle pulse, the engine owns the rest
  assign tally_clr = reg_wr && reg_addr == `IMUST_ADDR_CMD &&
                     reg_wdata == `IMUST_CMD_TALLY_CLR;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      foc_start <= 1'b0;
    end else begin
      foc_start <= reg_wr && reg_addr == `IMUST_ADDR_CMD &&
                   reg_wdata == `IMUST_CMD_FOC;
    end
  end

  // step total; a clear in the same cycle as a step wins over it
  // because the command restarts the count from zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tally_q <= 16'h0000;
    end else if (tally_clr) begin
      tally_q <= 16'h0000;
    end else if (step_pulse) begin
      tally_q <= tally_q + 16'h0001;
    end
  end

  // remember which register the read targets for the mux stage
  // only a read strobe moves it, so idle address changes between
  // reads cannot disturb the answer, except for trim bytes, which storage reads off the live address
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_addr_q <= 8'h00;
    end else if (reg_rd) begin
      rd_addr_q <= reg_addr;
    end
  end

  // read mux: trim data arrives one cycle later from storage,
  // so every read answers two cycles after the strobe
  // tally bytes are read live: a step between the two byte reads can
  // tear the pair, so software reads low, then high, then re-checks
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      case (rd_addr_q)
        `IMUST_ADDR_CHECK: reg_rdata <= check_q;
        `IMUST_ADDR_BOOT: reg_rdata <= boot_q;
        `IMUST_ADDR_TALLY_LO: reg_rdata <= tally_q[7:0];
        `IMUST_ADDR_TALLY_HI: reg_rdata <= tally_q[15:8];
        default: begin
          if (rd_addr_q >= `IMUST_ADDR_TRIM0 &&
              rd_addr_q <= `IMUST_ADDR_TRIM6) begin
            reg_rdata <= trim_rd;
          end else begin
            reg_rdata <= 8'h00;
          end
        end
      endcase
    end
  end

  // sign-extend each offset to sample width
  // gyro upper bits sit two per axis in the top trim byte
  always_comb begin
    off_vec[0] = {{8{trim_img[7]}}, trim_img[7:0]};
    off_vec[1] = {{8{trim_img[15]}}, trim_img[15:8]};
    off_vec[2] = {{8{trim_img[23]}}, trim_img[23:16]};
    off_vec[3] = {{6{trim_img[49]}}, trim_img[49:48],
                  trim_img[31:24]};
    off_vec[4] = {{6{trim_img[51]}}, trim_img[51:50], trim_img[39:32]};
    off_vec[5] = {{6{trim_img[53]}}, trim_img[53:52], trim_img[47:40]};
    raw_vec[0] = acc_x;
    raw_vec[1] = acc_y;
    raw_vec[2] = acc_z;
    raw_vec[3] = gyr_x;
    raw_vec[4] = gyr_y;
    raw_vec[5] = gyr_z;
  end

  // trim enables live in the top byte of the trim image; a sample
  // that arrives with the enabling write still passes uncorrected,
  // since the byte lands in storage one edge later
  assign acc_trim_on = trim_img[48 + `IMUST_BIT_ACC_TRIM];
  assign gyr_trim_on = trim_img[48 + `IMUST_BIT_GYR_TRIM];
  assign trim_on = {{3{gyr_trim_on}}, {3{acc_trim_on}}};

  // offset adders; wrap-around is accepted, the sensor has headroom
  // accel offsets are added at the raw lsb weight; matching them to
  // the selected range is left to the filter stage upstream
  logic [15:0] adj_q [6]; // corrected samples
  for (genvar a = 0; a < 6; a++) begin : g_adj
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        adj_q[a] <= 16'h0000;
      end else if (samp_valid) begin
        if (trim_on[a]) begin
          adj_q[a] <= raw_vec[a] + off_vec[a];
        end else begin
          adj_q[a] <= raw_vec[a];
        end
      end
    end
  end
  assign acc_x_o = adj_q[0];
  assign acc_y_o = adj_q[1];
  assign acc_z_o = adj_q[2];
  assign gyr_x_o = adj_q[3];
  assign gyr_y_o = adj_q[4];
  assign gyr_z_o = adj_q[5];
endmodule

/* logic/imust_cfg.svh */
// register map, field positions, reset values and timing counts
// assumes a core clock of 20 MHz and an 8-bit internal register port
`ifndef IMUST_CFG_SVH
`define IMUST_CFG_SVH
`define IMUST_ADDR_CHECK 8'h6d
`define IMUST_ADDR_BOOT 8'h70
`define IMUST_ADDR_TRIM0 8'h71
`define IMUST_ADDR_TRIM6 8'h77
`define IMUST_ADDR_TALLY_LO 8'h78
`define IMUST_ADDR_TALLY_HI 8'h79
`define IMUST_ADDR_CMD 8'h7e
`define IMUST_CMD_FOC 8'h03
`define IMUST_CMD_TALLY_CLR 8'hb2
`define IMUST_CHECK_RST 8'h00
`define IMUST_CHECK_MASK 8'h1f
`define IMUST_BOOT_MASK 8'h07
`define IMUST_ACC_RUN 2'h1
`define IMUST_BIT_GYR_CHK 4
`define IMUST_BIT_AMP 3
`define IMUST_BIT_SIGN 2
`define IMUST_BIT_WDT_EN 2
`define IMUST_BIT_WDT_SEL 1
`define IMUST_BIT_SER_ONLY 0
`define IMUST_BIT_GYR_TRIM 7
`define IMUST_BIT_ACC_TRIM 6
`define IMUST_CLK_HZ 20000000
`define IMUST_WDT_SHORT_MS 1
`define IMUST_WDT_LONG_MS 50
`define IMUST_WDT_SHORT_CYC (`IMUST_CLK_HZ / 1000 * `IMUST_WDT_SHORT_MS)
`define IMUST_WDT_LONG_CYC (`IMUST_CLK_HZ / 1000 * `IMUST_WDT_LONG_MS)
`endif

/* logic/imust_pkg.sv */
// types shared by the trim and self-check register bank
// assumes nothing beyond a SystemVerilog compiler
package imust_pkg;
  typedef logic [7:0] imust_byte_t; // one register byte
  typedef logic [15:0] imust_word_t; // one sensor sample
  typedef enum logic [1:0] {
    IMUST_IF_AUTO, IMUST_IF_I2C, IMUST_IF_AUTO_MAG, IMUST_IF_RSVD
  } imust_ifmode_e;
endpackage

/* logic/imust_trim_mem.sv */
// seven-byte trim storage with registered read data
// assumes one write port and one read port on the same clock
`timescale 1ns/1ns
module imust_trim_mem #(
  parameter int DEPTH = 7,
  parameter int AW = 3
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [7:0] wr_data,
  // read side
  input wire logic [AW-1:0] rd_idx,
  output logic [7:0] rd_data,
  // whole image for the datapath
  output logic [8*DEPTH-1:0] image
);
  logic [7:0] mem_q [DEPTH]; // storage bytes

  // one storage byte per generate entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_byte
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        mem_q[i] <= 8'h00;
      end else if (wr_en && wr_idx == AW'(i)) begin
        mem_q[i] <= wr_data;
      end
    end
    assign image[8*i +: 8] = mem_q[i];
  end

  // registered read so the bus sees a flop
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (rd_idx < AW'(DEPTH)) begin
      rd_data <= mem_q[rd_idx];
    end else begin
      rd_data <= 8'h00;
    end
  end
endmodule

/* tb/imust_regs_monitor.sv */
// port assertions for the trim and self-check bank
// assumes one clock and a sync active-low reset
`timescale 1ns/1ns
module imust_regs_monitor #(
  parameter int WDT_SHORT_CYC = 20,
  parameter int WDT_LONG_CYC = 50
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register writes
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire imust_pkg::imust_byte_t reg_wdata,
  // self-test
  input wire logic gyr_check_ok,
  input wire logic gyr_check_run,
  input wire logic [2:0] acc_check_axes,
  input wire logic acc_check_high,
  input wire logic acc_check_pos,
  input wire logic gyr_check_ok_flag,
  // steering and commands
  input wire imust_pkg::imust_ifmode_e if_mode,
  input wire logic sda_pin,
  input wire logic two_wire_off,
  input wire logic bus_wdt_expired,
  input wire logic foc_start
);
  import imust_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic chk_wr; // write to the self-check byte
  int low_q; // raw low run; the syncs only lengthen it
  assign chk_wr = reg_wr && reg_addr == 8'h6d;
  // count data line low cycles
  always_ff @(posedge core_clk) begin
    low_q <= (!rst_n || sda_pin) ? 0 : low_q + 1;
  end
  property p_run;
    chk_wr |-> ##2 gyr_check_run == $past(reg_wdata[4], 2);
  endproperty
  a_run: assert property (p_run) else $error("gyro run bit");
  property p_amp;
    chk_wr |-> ##2 acc_check_high == $past(reg_wdata[3], 2);
  endproperty
  a_amp: assert property (p_amp) else $error("amplitude bit");
  property p_sign;
    chk_wr |-> ##2 acc_check_pos == $past(reg_wdata[2], 2);
  endproperty
  a_sign: assert property (p_sign) else $error("sign bit");
  property p_axes;
    chk_wr |-> ##2 acc_check_axes ==
      ($past(reg_wdata[1:0], 2) == 2'h1 ? 3'h7 : 3'h0);
  endproperty
  a_axes: assert property (p_axes) else $error("axes");
  property p_ok;
    $past(gyr_check_run && gyr_check_ok) && gyr_check_run
      |-> gyr_check_ok_flag;
  endproperty
  a_ok: assert property (p_ok) else $error("gyro ok flag");
  property p_foc;
    reg_wr && reg_addr == 8'h7e && reg_wdata == 8'h03
      |=> foc_start ##1 !foc_start;
  endproperty
  a_foc: assert property (p_foc) else $error("calib start");
  property p_ser;
    two_wire_off |-> $past(if_mode) inside {IMUST_IF_AUTO, IMUST_IF_AUTO_MAG};
  endproperty
  a_ser: assert property (p_ser) else $error("two wire off");
  property p_wdt;
    $rose(bus_wdt_expired) |-> low_q >= WDT_SHORT_CYC - 1;
  endproperty
  a_wdt: assert property (p_wdt) else $error("early dog");
  c_foc: cover property (foc_start);
  c_wdt: cover property ($rose(bus_wdt_expired));
  c_axes: cover property (acc_check_axes == 3'h7);
endmodule
bind imust_regs imust_regs_monitor #(
  .WDT_SHORT_CYC(WDT_SHORT_CYC), .WDT_LONG_CYC(WDT_LONG_CYC)
) u_imust_regs_monitor (
  .core_clk, .rst_n, .reg_wr, .reg_addr, .reg_wdata, .gyr_check_ok,
  .gyr_check_run, .acc_check_axes, .acc_check_high, .acc_check_pos,
  .gyr_check_ok_flag, .if_mode, .sda_pin, .two_wire_off,
  .bus_wdt_expired, .foc_start
);

/* tb/imust_host_model.sv */
// host model on the bank's register port
// assumes reset is released before the first call
`timescale 1ns/1ns
module imust_host_model (
  // clock
  input wire logic core_clk,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output imust_pkg::imust_byte_t reg_wdata,
  input wire imust_pkg::imust_byte_t reg_rdata
);
  import imust_pkg::*;
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  // write; idle lines flip so stale values never match
  task automatic wr(logic [7:0] a, imust_byte_t d);
    @(posedge core_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge core_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
  endtask
  // read; address held past the latch edge
  task automatic rd(logic [7:0] a, output imust_byte_t d);
    @(posedge core_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    reg_addr <= ~a;
    @(posedge core_clk);
    #1 d = reg_rdata;
  endtask
  // accel check: rate setup first, settle before results
  task automatic acc_check(imust_byte_t v, int settle);
    wr(8'h40, 8'h2c);
    wr(8'h6d, v);
    repeat (settle) @(posedge core_clk);
  endtask
endmodule

/* tb/tb_top.sv */
// bench for the trim and self-check register bank
// assumes short watchdog counts of 20 and 50 cycles
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end end
module tb_top;
  import imust_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n, reg_wr, reg_rd, nv_load, foc_done, step_pulse, samp_valid;
  logic gyr_check_ok, acc_check_ok, gyr_check_run, acc_check_high;
  logic acc_check_pos, gyr_check_ok_flag, acc_check_ok_flag, foc_start;
  logic sda_pin, two_wire_off, bus_wdt_expired;
  logic [7:0] reg_addr, nv_addr;
  logic [2:0] foc_idx, acc_check_axes;
  imust_byte_t reg_wdata, reg_rdata, nv_data, foc_data;
  imust_ifmode_e if_mode;
  imust_word_t acc_x, acc_y, acc_z, gyr_x, gyr_y, gyr_z;
  imust_word_t acc_x_o, acc_y_o, acc_z_o, gyr_x_o, gyr_y_o, gyr_z_o;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  imust_regs #(.WDT_SHORT_CYC(20), .WDT_LONG_CYC(50)) u_imust_regs (
    .core_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .nv_load, .nv_addr, .nv_data, .foc_done, .foc_idx,
    .foc_data, .gyr_check_ok, .acc_check_ok, .gyr_check_run,
    .acc_check_axes, .acc_check_high, .acc_check_pos, .gyr_check_ok_flag,
    .acc_check_ok_flag, .if_mode, .sda_pin, .two_wire_off,
    .bus_wdt_expired, .step_pulse, .foc_start, .samp_valid, .acc_x,
    .acc_y, .acc_z, .gyr_x, .gyr_y, .gyr_z, .acc_x_o, .acc_y_o, .acc_z_o,
    .gyr_x_o, .gyr_y_o, .gyr_z_o);
  imust_host_model u_imust_host_model (.core_clk, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata);
  always #25 core_clk = ~core_clk;
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, imust_byte_t d);
    u_imust_host_model.wr(a, d);
  endtask
  task automatic rd_chk(string nm, logic [7:0] a, imust_byte_t e);
    imust_byte_t v;
    u_imust_host_model.rd(a, v);
    `CHK(nm, e, v)
  endtask
  // boot stream byte, one edge wide
  task automatic nv_put(logic [7:0] a, imust_byte_t d);
    @(posedge core_clk);
    {nv_load, nv_addr, nv_data} <= {1'b1, a, d};
    @(posedge core_clk);
    nv_load <= 1'b0;
  endtask
  task automatic sda_hold(logic lvl, int n);
    @(posedge core_clk);
    sda_pin <= lvl;
    tick(n);
  endtask
  task automatic samp(imust_word_t ax, imust_word_t ay, imust_word_t gx);
    @(posedge core_clk);
    {samp_valid, acc_x, acc_y, acc_z} <= {1'b1, ax, ay, ay};
    {gyr_x, gyr_y, gyr_z} <= {gx, gx, gx};
    @(posedge core_clk);
    samp_valid <= 1'b0;
    #1;
  endtask
  task automatic t_check();
    rd_chk("check rst", 8'h6d, 8'h00);
    rd_chk("unmapped", 8'h40, 8'h00);
    wr(8'h6d, 8'hff);
    rd_chk("check mask", 8'h6d, 8'h1f);
    `CHK("axes idle", 3'h0, acc_check_axes)
    @(posedge core_clk);
    {gyr_check_ok, acc_check_ok} <= 2'h3;
    tick(3);
    `CHK("gyro ok", 1'b1, gyr_check_ok_flag)
    u_imust_host_model.acc_check(8'h0d, 40);
    #1 `CHK("axes run", 3'h7, acc_check_axes)
    `CHK("amp high", 1'b1, acc_check_high)
    `CHK("sign pos", 1'b1, acc_check_pos)
    `CHK("acc ok", 1'b1, acc_check_ok_flag)
    wr(8'h6d, 8'h01);
    tick(1); // drives follow the control byte one edge later
    `CHK("amp low", 1'b0, acc_check_high)
    `CHK("sign neg", 1'b0, acc_check_pos)
    $display("test self-check done");
  endtask
  // serial-only, then the dog at both periods
  task automatic t_boot();
    nv_put(8'h70, 8'hfd);
    tick(2);
    `CHK("serial only", 1'b1, two_wire_off)
    rd_chk("boot cfg", 8'h70, 8'h05);
    @(posedge core_clk);
    if_mode <= IMUST_IF_AUTO_MAG;
    tick(2);
    `CHK("mag serial only", 1'b1, two_wire_off)
    @(posedge core_clk);
    if_mode <= IMUST_IF_I2C;
    tick(2);
    `CHK("two wire", 1'b0, two_wire_off)
    sda_hold(1'b0, 30);
    `CHK("short dog", 1'b1, bus_wdt_expired)
    sda_hold(1'b1, 5);
    nv_put(8'h70, 8'h06);
    sda_hold(1'b0, 30);
    `CHK("long wait", 1'b0, bus_wdt_expired)
    sda_hold(1'b0, 30);
    `CHK("long dog", 1'b1, bus_wdt_expired)
    sda_hold(1'b1, 5);
    nv_put(8'h70, 8'h00);
    sda_hold(1'b0, 30);
    `CHK("dog off", 1'b0, bus_wdt_expired)
    sda_hold(1'b1, 5);
    $display("test boot done");
  endtask
  task automatic t_trim();
    nv_put(8'h71, 8'hff);
    nv_put(8'h74, 8'h00);
    wr(8'h73, 8'h80);
    wr(8'h75, 8'h03);
    wr(8'h77, 8'hf2);
    @(posedge core_clk);
    {foc_done, foc_idx, foc_data} <= {1'b1, 3'h1, 8'h05};
    @(posedge core_clk);
    foc_done <= 1'b0;
    rd_chk("calib byte", 8'h72, 8'h05);
    samp(16'h0010, 16'h0100, 16'h1000);
    `CHK("acc x", 16'h000f, acc_x_o)
    `CHK("acc y", 16'h0105, acc_y_o)
    `CHK("gyr x", 16'h0e00, gyr_x_o)
    `CHK("acc z", 16'h0080, acc_z_o)
    `CHK("gyr y", 16'h1003, gyr_y_o)
    `CHK("gyr z", 16'h0f00, gyr_z_o)
    wr(8'h77, 8'h02);
    samp(16'h0010, 16'h0100, 16'h1000);
    `CHK("acc raw", 16'h0010, acc_x_o)
    `CHK("gyr raw", 16'h1000, gyr_x_o)
    `CHK("acc z raw", 16'h0100, acc_z_o)
    `CHK("gyr z raw", 16'h1000, gyr_z_o)
    $display("test trim done");
  endtask
  // step pulses, one edge high and one edge low each
  task automatic steps(int n);
    repeat (n) begin
      @(posedge core_clk);
      step_pulse <= 1'b1;
      @(posedge core_clk);
      step_pulse <= 1'b0;
    end
  endtask
  task automatic t_step();
    rd_chk("tally rst", 8'h79, 8'h00);
    steps(3);
    wr(8'h78, 8'h55);
    rd_chk("tally lo", 8'h78, 8'h03);
    wr(8'h7e, 8'hb2);
    rd_chk("tally clr", 8'h78, 8'h00);
    steps(257);
    rd_chk("tally hi", 8'h79, 8'h01);
    rd_chk("tally carry", 8'h78, 8'h01);
    // clear and a step in one cycle: the clear wins
    fork
      wr(8'h7e, 8'hb2);
      steps(1);
    join
    rd_chk("clear beats step", 8'h78, 8'h00);
    wr(8'h7e, 8'h03);
    #1 `CHK("calib go", 1'b1, foc_start)
    $display("test step done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // hang guard, well above the eight hundred or so cycles needed
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    {rst_n, nv_load, foc_done, step_pulse, samp_valid} = '0;
    {gyr_check_ok, acc_check_ok, nv_addr, nv_data, foc_idx, foc_data} = '0;
    {acc_x, acc_y, acc_z, gyr_x, gyr_y, gyr_z} = '0;
    if_mode = IMUST_IF_AUTO;
    sda_pin = 1'b1;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    t_check();
    t_boot();
    t_trim();
    t_step();
    complete_run();
  end
endmodule
